// ==== verilog/smc_top.v ====
// shared memory concentrator: bit/word store plus pair-connection scheduler
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "smc_defines.vh"

// Overview of operation
// - bit view and word view share one storage array
// - word location equals (bit location minus 3000) div 16 plus 3000
// - a word access reads or writes all sixteen cells together
// - both views return identical content, no copies kept
// - lowest bit location is word lsb
// - sixteen independently configured pair-connection entries
// - entry with zero item count is disabled
// - pull fetches remote into store, push sends store out
// - pull writes received bits upward from configured store start
// - each entry holds remote ip address and tcp port
// - any host reads what another host wrote
// - push entries forward host-written store values to remote
// - store holds 256 words, 4096 bits
module smc_top (
   input  wire        i_clk,
   input  wire        i_rst,
   // host word port
   input  wire [15:0] i_word_view_location,
   input  wire [15:0] i_word_wdata,
   input  wire        i_word_wr,
   input  wire        i_word_rd,
   output reg  [15:0] o_word_rdata,
   output reg         o_word_err,
   // host bit port
   input  wire [15:0] i_bit_view_location,
   input  wire        i_bit_wdata,
   input  wire        i_bit_wr,
   input  wire        i_bit_rd,
   output reg         o_bit_rdata,
   output reg         o_bit_err,
   // entry configuration
   input  wire        i_cfg_wr,
   input  wire [3:0]  i_cfg_idx,
   input  wire        i_cfg_dir,
   input  wire [31:0] i_cfg_ip,
   input  wire [15:0] i_cfg_port,
   input  wire [15:0] i_cfg_scan_ms,
   input  wire [15:0] i_cfg_count,
   input  wire [15:0] i_cfg_local,
   input  wire [15:0] i_cfg_remote,
   // remote link: request out, data exchanged one bit per cycle
   output reg         o_req_valid,
   input  wire        i_req_ready,
   output reg  [3:0]  o_req_idx,
   output reg         o_req_dir,
   output reg  [31:0] o_req_ip,
   output reg  [15:0] o_req_port,
   output reg  [15:0] o_req_remote,
   output reg  [15:0] o_req_count,
   input  wire        i_pull_valid,
   input  wire        i_pull_bit,
   output reg         o_push_valid,
   output reg         o_push_bit,
   input  wire        i_push_ready,
   output wire        o_busy
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function [12:0] bit_idx;
      input [15:0] loc;
      reg   [15:0] off;
      begin
         off = loc - `SMC_BASE_LOC;
         bit_idx = off[12:0];
      end
   endfunction

   function bit_ok;
      input [15:0] loc;
      begin
         bit_ok = (loc >= `SMC_BASE_LOC) && (loc <= `SMC_BIT_LAST);
      end
   endfunction

   function word_ok;
      input [15:0] loc;
      begin
         word_ok = (loc >= `SMC_BASE_LOC) && (loc <= `SMC_WORD_LAST);
      end
   endfunction

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg [15:0] mem_q [0:255];

   reg [15:0] widx_off;
   reg [7:0]  widx;
   reg        wok;
   reg [12:0] hbi;
   reg        hbok;
   always @* begin
      widx_off = i_word_view_location - `SMC_BASE_LOC;
      widx = widx_off[7:0];
      wok = word_ok(i_word_view_location);
      hbi = bit_idx(i_bit_view_location);
      hbok = bit_ok(i_bit_view_location);
   end

   // ------------------------------------------------------------
   // entry table
   // ------------------------------------------------------------
   reg        dir_q    [0:15];
   reg [31:0] ip_q     [0:15];
   reg [15:0] port_q   [0:15];
   reg [15:0] scan_q   [0:15];
   reg [15:0] count_q  [0:15];
   reg [15:0] local_q  [0:15];
   reg [15:0] remote_q [0:15];
   reg [31:0] tmr_q    [0:15];
   reg [15:0] due_q;

   // ------------------------------------------------------------
   // transfer engine
   // ------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_REQ  = 4'h2;
   localparam [3:0] ST_PULL = 4'h4;
   localparam [3:0] ST_PUSH = 4'h8;

   reg [3:0]  state_q;
   reg [3:0]  cur_q;
   reg [15:0] left_q;
   reg [15:0] ptr_q;
   reg [3:0]  pick;
   reg        found;
   integer    k;

   assign o_busy = (state_q != ST_IDLE);

   always @* begin
      pick = 4'h0;
      found = 1'b0;
      for (k = 15; k >= 0; k = k - 1) begin
         if (due_q[k]) begin
            pick = k[3:0];
            found = 1'b1;
         end
      end
   end

   wire [12:0] ebi = bit_idx(ptr_q);
   wire        ebok = bit_ok(ptr_q);
   wire        pull_wr = (state_q == ST_PULL) && i_pull_valid && ebok;
   wire        push_go = (state_q == ST_PUSH) && i_push_ready;
   wire [15:0] nxt_ptr = ptr_q + 16'h0001;
   wire [12:0] nbi = bit_idx(nxt_ptr);
   wire        nbok = bit_ok(nxt_ptr);

   // one-hot grant of the entry that the idle engine takes this cycle
   reg  [15:0] grant;
   always @* begin
      grant = 16'h0000;
      if ((state_q == ST_IDLE) && found) begin
         grant[pick] = 1'b1;
      end
   end

   integer j;
   always @(posedge i_clk) begin
      if (i_rst) begin
         for (j = 0; j < 256; j = j + 1) begin
            mem_q[j] <= 16'h0000;
         end
         for (j = 0; j < 16; j = j + 1) begin
            dir_q[j] <= `SMC_DIR_PULL;
            ip_q[j] <= 32'h0000_0000;
            port_q[j] <= 16'h0000;
            scan_q[j] <= `SMC_SCAN_MS_RST;
            count_q[j] <= 16'h0000;
            local_q[j] <= 16'h0000;
            remote_q[j] <= 16'h0000;
            tmr_q[j] <= 32'h0000_0000;
         end
         due_q <= 16'h0000;
         o_word_rdata <= 16'h0000;
         o_word_err <= 1'b0;
         o_bit_rdata <= 1'b0;
         o_bit_err <= 1'b0;
         state_q <= ST_IDLE;
         cur_q <= 4'h0;
         left_q <= 16'h0000;
         ptr_q <= 16'h0000;
         o_req_valid <= 1'b0;
         o_req_idx <= 4'h0;
         o_req_dir <= 1'b0;
         o_req_ip <= 32'h0000_0000;
         o_req_port <= 16'h0000;
         o_req_remote <= 16'h0000;
         o_req_count <= 16'h0000;
         o_push_valid <= 1'b0;
         o_push_bit <= 1'b0;
      end else begin
         // host reads see the same cells whichever view is used
         o_word_err <= i_word_rd && !wok;
         o_bit_err <= i_bit_rd && !hbok;
         if (i_word_rd) begin
            o_word_rdata <= wok ? mem_q[widx] : 16'h0000;
         end
         if (i_bit_rd) begin
            o_bit_rdata <= hbok ? mem_q[hbi[11:4]][hbi[3:0]] : 1'b0;
         end
         // writes: host word, then host bit, then engine pull last
         if (i_word_wr && wok) begin
            mem_q[widx] <= i_word_wdata;
         end
         if (i_bit_wr && hbok) begin
            mem_q[hbi[11:4]][hbi[3:0]] <= i_bit_wdata;
         end
         if (pull_wr) begin
            mem_q[ebi[11:4]][ebi[3:0]] <= i_pull_bit;
         end
         // configuration
         if (i_cfg_wr) begin
            dir_q[i_cfg_idx] <= i_cfg_dir;
            ip_q[i_cfg_idx] <= i_cfg_ip;
            port_q[i_cfg_idx] <= i_cfg_port;
            scan_q[i_cfg_idx] <= i_cfg_scan_ms;
            count_q[i_cfg_idx] <= i_cfg_count;
            local_q[i_cfg_idx] <= i_cfg_local;
            remote_q[i_cfg_idx] <= i_cfg_remote;
         end
         // scan timers; a due flag set in the clearing cycle wins
         for (j = 0; j < 16; j = j + 1) begin
            if (count_q[j] == 16'h0000) begin
               tmr_q[j] <= 32'h0000_0000;
               due_q[j] <= 1'b0;
            end else if (tmr_q[j] + 32'h0000_0001 >=
                         scan_q[j] * `SMC_CLK_KHZ) begin
               tmr_q[j] <= 32'h0000_0000;
               due_q[j] <= 1'b1;
            end else begin
               tmr_q[j] <= tmr_q[j] + 32'h0000_0001;
               if (grant[j]) begin
                  due_q[j] <= 1'b0;
               end
            end
         end
         case (state_q)
            ST_IDLE: begin
               if (found) begin
                  cur_q <= pick;
                  o_req_valid <= 1'b1;
                  o_req_idx <= pick;
                  o_req_dir <= dir_q[pick];
                  o_req_ip <= ip_q[pick];
                  o_req_port <= port_q[pick];
                  o_req_remote <= remote_q[pick];
                  o_req_count <= count_q[pick];
                  left_q <= count_q[pick];
                  ptr_q <= local_q[pick];
                  state_q <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (i_req_ready) begin
                  o_req_valid <= 1'b0;
                  state_q <= (o_req_dir == `SMC_DIR_PUSH) ? ST_PUSH : ST_PULL;
                  if (o_req_dir == `SMC_DIR_PUSH) begin
                     o_push_valid <= 1'b1;
                     o_push_bit <= ebok ? mem_q[ebi[11:4]][ebi[3:0]] : 1'b0;
                  end
               end
            end
            ST_PULL: begin
               if (i_pull_valid) begin
                  ptr_q <= ptr_q + 16'h0001;
                  left_q <= left_q - 16'h0001;
                  if (left_q == 16'h0001) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_PUSH: begin
               if (push_go) begin
                  ptr_q <= ptr_q + 16'h0001;
                  left_q <= left_q - 16'h0001;
                  if (left_q == 16'h0001) begin
                     o_push_valid <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     o_push_bit <= nbok ? mem_q[nbi[11:4]][nbi[3:0]] : 1'b0;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // smc_top
`default_nettype wire

// ==== verilog/smc_defines.vh ====
// constants for the shared memory concentrator
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
`define SMC_BASE_LOC      16'h0BB8
`define SMC_BITS_PER_WORD 5'h10
`define SMC_WORDS         9'h100
`define SMC_BITS          13'h1000
`define SMC_WORD_LAST     16'h0CB7
`define SMC_BIT_LAST      16'h1BB7
`define SMC_ENTRIES       5'h10
`define SMC_CLK_KHZ       32'h0000_2710
`define SMC_SCAN_MS_RST   16'h03E8
`define SMC_DIR_PULL      1'h0
`define SMC_DIR_PUSH      1'h1
`define SMC_SCAN_LIM_RST  32'h0098_9680
`endif

// ==== verif/smc_checker.sv ====
// port checker for the shared memory concentrator
`timescale 1ns/100ps
`default_nettype none
module smc_checker (
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic [15:0] i_word_view_location,
   input wire logic [15:0] i_word_wdata,
   input wire logic        i_word_wr,
   input wire logic        i_word_rd,
   input wire logic [15:0] o_word_rdata,
   input wire logic        o_word_err,
   input wire logic [15:0] i_bit_view_location,
   input wire logic        i_bit_wr,
   input wire logic        i_bit_rd,
   input wire logic        o_bit_rdata,
   input wire logic        o_bit_err,
   input wire logic        o_req_valid,
   input wire logic        i_req_ready,
   input wire logic [15:0] o_req_count,
   input wire logic        o_push_valid,
   input wire logic        o_push_bit,
   input wire logic        i_push_ready,
   input wire logic        o_busy
);
   // ----------
   // relations
   // ----------
   wire w_in = i_word_view_location >= 16'h0BB8 && i_word_view_location <= 16'h0CB7;
   wire b_in = i_bit_view_location >= 16'h0BB8 && i_bit_view_location <= 16'h1BB7;
   wire [15:0] b_off = i_bit_view_location - 16'h0BB8;
   wire [15:0] b_wl = (b_off >> 4) + 16'h0BB8;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_WRD_OOR: assert property (i_word_rd && !w_in |=> o_word_err && !o_word_rdata)
      else $error("word read out of range not refused");
   AST_BIT_OOR: assert property (i_bit_rd && !b_in |=> o_bit_err && !o_bit_rdata)
      else $error("bit read out of range not refused");
   AST_WRD_OK: assert property (i_word_rd && w_in |=> !o_word_err)
      else $error("error on a word read in range");
   AST_ERR_SRC: assert property (o_word_err |-> $past(i_word_rd))
      else $error("word error without a read");
   AST_WB: assert property ((i_word_wr && w_in && !o_busy) ##2 (i_word_rd && !o_busy
      && i_word_view_location == $past(i_word_view_location, 2)) |=>
      o_word_rdata == $past(i_word_wdata, 3)) else $error("word read back differs");
   AST_W2B: assert property ((i_word_wr && w_in && !o_busy) ##2 (i_bit_rd && !o_busy
      && b_wl == $past(i_word_view_location, 2)) |=> o_bit_rdata ==
      (($past(i_word_wdata, 3) >> $past(b_off[3:0])) & 16'h0001))
      else $error("bit view differs from word view");
   AST_REQ_HOLD: assert property (o_req_valid && !i_req_ready |=> o_req_valid
      && $stable(o_req_count)) else $error("request dropped before ready");
   AST_REQ_ON: assert property (o_req_valid |-> o_req_count != 16'h0000 && o_busy)
      else $error("request from a disabled entry");
   AST_PUSH_HOLD: assert property (o_push_valid && !i_push_ready |=> o_push_valid
      && $stable(o_push_bit)) else $error("push bit dropped before ready");
   cover property (o_req_valid && i_req_ready);
   cover property (o_push_valid && i_push_ready);
   cover property (o_word_err);
endmodule // smc_checker
bind smc_top smc_checker u_chk (.i_clk, .i_rst, .i_word_view_location, .i_word_wdata,
   .i_word_wr, .i_word_rd, .o_word_rdata, .o_word_err, .i_bit_view_location, .i_bit_wr,
   .i_bit_rd, .o_bit_rdata, .o_bit_err, .o_req_valid, .i_req_ready, .o_req_count,
   .o_push_valid, .o_push_bit, .i_push_ready, .o_busy);
`default_nettype wire

// ==== verif/smc_remote.sv ====
// remote slave model: slow ready, data beats only every other cycle
`timescale 1ns/100ps
`default_nettype none
module smc_remote #(
   parameter logic [15:0] PAT = 16'h0005
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_req_valid,
   input  wire logic        i_req_dir,
   input  wire logic [15:0] i_req_count,
   input  wire logic        i_push_valid,
   input  wire logic        i_push_bit,
   output var  logic        o_req_ready,
   output var  logic        o_pull_valid,
   output var  logic        o_pull_bit,
   output var  logic        o_push_ready,
   output var  logic [15:0] o_seen
);
   logic [15:0] n_q, c_q;
   logic        act_q, dir_q, ph_q;
   always @(posedge i_clk) begin
      if (i_rst) begin
         {o_req_ready, o_pull_valid, o_pull_bit, o_push_ready, act_q, dir_q, ph_q} <= 7'h00;
         {n_q, c_q, o_seen} <= 48'h0;
      end else begin
         ph_q         <= ~ph_q;
         o_req_ready  <= i_req_valid && !o_req_ready && !act_q && ph_q;
         o_pull_valid <= act_q && !dir_q && ph_q;
         // idle data line toggles so a stale bit is never read as good
         o_pull_bit   <= (act_q && ph_q) ? PAT[n_q[3:0]] : ~o_pull_bit;
         o_push_ready <= act_q && dir_q && ph_q;
         if (i_req_valid && o_req_ready) begin
            {act_q, dir_q, c_q, n_q} <= {1'b1, i_req_dir, i_req_count, 16'h0000};
         end else if (act_q && (dir_q ? i_push_valid && o_push_ready : ph_q)) begin
            if (dir_q) o_seen <= {i_push_bit, o_seen[15:1]};
            n_q   <= n_q + 16'h0001;
            act_q <= n_q + 16'h0001 != c_q;
         end
      end
   end
endmodule // smc_remote
`default_nettype wire

// ==== verif/smc_tb.sv ====
// self-checking testbench for the shared memory concentrator
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic i_clk = 1'b0, i_rst = 1'b1, i_word_wr = 1'b0, i_word_rd = 1'b0, i_bit_wdata = 1'b0;
   logic i_bit_wr = 1'b0, i_bit_rd = 1'b0, i_cfg_wr = 1'b0, i_cfg_dir = 1'b0;
   logic [15:0] i_word_view_location = 16'h0BB8, i_word_wdata = 16'h0000;
   logic [15:0] i_bit_view_location = 16'h0BB8, i_cfg_port = 16'h0000, i_cfg_scan_ms = 16'h0000;
   logic [15:0] i_cfg_count = 16'h0000, i_cfg_local = 16'h0000, i_cfg_remote = 16'h0000;
   logic [31:0] i_cfg_ip = 32'h0000_0000, r;
   logic [3:0]  i_cfg_idx = 4'h0;
   logic [31:0] ip_x [16], cyc = 32'h0, hs_cyc = 32'h0, t0 = 32'h0;
   logic [15:0] rem_x [16];
   wire [15:0] o_word_rdata, o_req_port, o_req_remote, o_req_count, seen;
   wire [31:0] o_req_ip;
   wire [3:0]  o_req_idx;
   wire o_word_err, o_bit_rdata, o_bit_err, o_req_valid, i_req_ready, o_req_dir, i_pull_valid;
   wire i_pull_bit, o_push_valid, o_push_bit, i_push_ready, o_busy;
   integer errors = 0, check_count = 0, seed = 32'hcd1d38a7;
   logic [16:0] exp_q[$];
   logic rdw = 1'b0, rdb = 1'b0;
   always #50 i_clk = ~i_clk;
   smc_top dut (.*);
   smc_remote rm (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(o_req_valid), .i_req_dir(o_req_dir),
      .i_req_count(o_req_count), .i_push_valid(o_push_valid), .i_push_bit(o_push_bit),
      .o_req_ready(i_req_ready), .o_pull_valid(i_pull_valid), .o_pull_bit(i_pull_bit),
      .o_push_ready(i_push_ready), .o_seen(seen));
   // -----------------
   // checks and report
   // -----------------
   task check(input string nm, input logic [16:0] s, e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge i_clk) {rdw, rdb} <= {i_word_rd, i_bit_rd};
   always @(posedge i_clk) cyc <= cyc + 32'h1;
   always @(negedge i_clk) if (rdw || rdb) begin
      if (exp_q.size() == 0) check("queue", 17'h00000, 17'h1FFFF);
      else check(rdw ? "word" : "bit", rdw ? {o_word_err, o_word_rdata} :
         {o_bit_err, 15'h0000, o_bit_rdata}, exp_q.pop_front());
   end
   // ------
   // driver
   // ------
   // k: 0 word write, 1 word read, 2 bit write, 3 bit read
   task op(input int k, input logic [15:0] a, d, input logic [16:0] e);
      @(posedge i_clk);
      {i_word_view_location, i_bit_view_location, i_word_wdata, i_bit_wdata} <= {a, a, d, d[0]};
      {i_word_wr, i_word_rd, i_bit_wr, i_bit_rd} <= {k == 0, k == 1, k == 2, k == 3};
      if (k == 1 || k == 3) exp_q.push_back(e);
      @(posedge i_clk);
      {i_word_wr, i_word_rd, i_bit_wr, i_bit_rd} <= 4'h0;
   endtask
   task cfg(input logic [3:0] ix, input logic dr, input logic [15:0] n, lc);
      ip_x[ix] = $random(seed);
      r = $random(seed);
      rem_x[ix] = r[15:0];
      @(posedge i_clk);
      {i_cfg_idx, i_cfg_dir, i_cfg_count, i_cfg_local, i_cfg_wr} <= {ix, dr, n, lc, 1'b1};
      {i_cfg_ip, i_cfg_remote} <= {ip_x[ix], rem_x[ix]};
      {i_cfg_port, i_cfg_scan_ms} <= {16'h01F6, 16'h0001};
      @(posedge i_clk);
      i_cfg_wr <= 1'b0;
   endtask
   task wait_x(input logic [3:0] ix, input logic dr, input logic [15:0] n);
      int k;
      for (k = 0; k < 30000 && !(o_req_valid && i_req_ready && o_req_dir == dr); k++)
         @(negedge i_clk);
      if (k == 30000) begin
         errors++;
         finish_test;
      end
      hs_cyc = cyc;
      check("idx", {13'h0000, o_req_idx}, {13'h0000, ix});
      check("count", {1'b0, o_req_count}, {1'b0, n});
      check("port", {1'b0, o_req_port}, 17'h001F6);
      check("ip_hi", {1'b0, o_req_ip[31:16]}, {1'b0, ip_x[ix][31:16]});
      check("ip_lo", {1'b0, o_req_ip[15:0]}, {1'b0, ip_x[ix][15:0]});
      check("remote", {1'b0, o_req_remote}, {1'b0, rem_x[ix]});
      for (k = 0; k < 300 && o_busy; k++) @(negedge i_clk);
      if (o_busy) begin
         errors++;
         finish_test;
      end
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      op(0, 16'h0BB8, 16'h00FF, 17'h0);
      for (int k = 0; k < 16; k++) op(3, 16'h0BB8 + k, 16'h0, {16'h0000, k < 8});
      op(2, 16'h0BC9, 16'h0001, 17'h0);
      op(1, 16'h0BB9, 16'h0000, 17'h00002);
      op(1, 16'h0CB8, 16'h0000, 17'h10000);
      op(3, 16'h1BB8, 16'h0000, 17'h10000);
      op(3, 16'h1BB7, 16'h0000, 17'h00000);
      repeat (6) begin
         r = $random(seed);
         op(0, 16'h0BC0 + r[22:16], r[15:0], 17'h0);
         op(1, 16'h0BC0 + r[22:16], 16'h0000, {1'b0, r[15:0]});
      end
      cfg(4'h2, 1'b0, 16'h0000, 16'h0BB8);
      cfg(4'h0, 1'b0, 16'h0004, 16'h0BE8);
      wait_x(4'h0, 1'b0, 16'h0004);
      op(1, 16'h0BBB, 16'h0000, 17'h00005);
      op(0, 16'h0BB8, 16'h000A, 17'h0);
      cfg(4'h1, 1'b1, 16'h0004, 16'h0BB8);
      wait_x(4'h1, 1'b1, 16'h0004);
      check("pushed", {13'h0000, seen[15:12]}, 17'h0000A);
      // scan of 1 ms at 10 MHz: 10000 cycles between two exchanges
      wait_x(4'h0, 1'b0, 16'h0004);
      t0 = hs_cyc;
      wait_x(4'h0, 1'b0, 16'h0004);
      t0 = hs_cyc - t0;
      check("period", t0[16:0], 17'h02710);
      finish_test;
   end
endmodule // testbench
`default_nettype wire
